//--- shared/igdc_pkg.sv
// Shared constants of the isolated gate driver control block
package igdc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock
  localparam int CLK_PERIOD_PS = 5000;  // 200 MHz core clock

  // Least time rounds up, never below one cycle
  function automatic int igdc_min_cycles(input int time_ns);
    int c;
    c = (time_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : igdc_min_cycles

  ////////////////////////////////////////////////////////////////////////
  // Timing constants, each as a time and a derived cycle count
  localparam int MIN_PULSE_NS   = 40;    // Glitch rejection width
  localparam int RESET_HOLD_NS  = 1000;  // Low time that clears a fault
  localparam int BLANKING_NS    = 2500;  // Desaturation blanking interval
  localparam int WATCHDOG_NS    = 2000;  // Transmission watchdog timeout

  localparam int MIN_PULSE_CYC  = igdc_min_cycles(MIN_PULSE_NS);
  localparam int RESET_HOLD_CYC = igdc_min_cycles(RESET_HOLD_NS);
  localparam int BLANKING_CYC   = igdc_min_cycles(BLANKING_NS);
  localparam int WATCHDOG_CYC   = igdc_min_cycles(WATCHDOG_NS);

  // Width of every timing counter
  localparam int CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and undriven pin defaults
  localparam logic NONINV_FLOAT_LEVEL = 1'b0;  // Pull-down on the non-inverting input
  localparam logic INV_FLOAT_LEVEL    = 1'b1;  // Pull-up on the inverting input
  localparam logic ENABLE_FLOAT_LEVEL = 1'b1;  // Pull-up on the reset/enable input
  localparam logic LOCK_RESET_VALUE   = 1'b1;  // Supplies count as low until proven

  ////////////////////////////////////////////////////////////////////////
  // Drive state machine, one-hot
  typedef enum logic [3:0] {
    IGDC_OFF   = 4'b0001,  // Gate held off
    IGDC_BLANK = 4'b0010,  // Gate on, detector blanked
    IGDC_RUN   = 4'b0100,  // Gate on, detector armed
    IGDC_FAULT = 4'b1000   // Desaturation fault latched
  } igdc_drive_type;

endpackage : igdc_pkg

//--- src/igdc_pin_filter.sv
`timescale 1ns/1ps
// Two-flop synchroniser followed by a minimum-width pulse filter
module igdc_pin_filter #(
  parameter int               MIN_CYC   = igdc_pkg::MIN_PULSE_CYC,
  parameter logic             RST_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // Pin level and filtered level
  input  wire logic i_pin,
  output logic      o_level
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]                  sync;    // Synchroniser chain
    logic                        level;   // Accepted level
    logic [igdc_pkg::CNT_W-1:0]  run;     // Cycles the new level has held
  } igdc_filt_type;

  igdc_filt_type st;       // Registered state
  igdc_filt_type next_st;  // Next state

  // A change is accepted only after it held MIN_CYC cycles; shorter pulses vanish
  always_comb begin
    next_st = st;
    next_st.sync = {st.sync[0], i_pin};
    if (st.sync[1] == st.level) begin
      next_st.run = '0;  // Back to the accepted level: drop the candidate
    end else if (st.run >= igdc_pkg::CNT_W'(MIN_CYC - 1)) begin
      next_st.level = st.sync[1];
      next_st.run   = '0;
    end else begin
      next_st.run = st.run + 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st <= '{sync: {2{RST_LEVEL}}, level: RST_LEVEL, run: '0};
    end else begin
      st <= next_st;
    end
  end

  assign o_level = st.level;

endmodule : igdc_pin_filter

//--- src/igdc_watchdog.sv
`timescale 1ns/1ps
// Watchdog on the internal transmission heartbeat
module igdc_watchdog #(
  parameter int TIMEOUT_CYC = igdc_pkg::WATCHDOG_CYC
) (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // Monitoring window and heartbeat toggle from the link
  input  wire logic i_active,
  input  wire logic i_beat,
  // Transmission failure, a level
  output logic      o_error
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]                  sync;   // Synchroniser chain
    logic                        prev;   // Last synchronised beat level
    logic [igdc_pkg::CNT_W-1:0]  quiet;  // Cycles since the last beat
    logic                        error;  // Timeout seen
  } igdc_wd_type;

  igdc_wd_type st;       // Registered state
  igdc_wd_type next_st;  // Next state

  // Any beat edge restarts the count and clears the error on its own
  always_comb begin
    next_st = st;
    next_st.sync = {st.sync[0], i_beat};
    next_st.prev = st.sync[1];
    if (!i_active || (st.sync[1] != st.prev)) begin
      next_st.quiet = '0;
      next_st.error = 1'b0;
    end else if (st.quiet >= igdc_pkg::CNT_W'(TIMEOUT_CYC - 1)) begin
      next_st.error = 1'b1;  // Saturate, stay in error until a beat or until i_active drops
    end else begin
      next_st.quiet = st.quiet + 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_error = st.error;

endmodule : igdc_watchdog

//--- src/igdc_core.sv
`timescale 1ns/1ps
module igdc_core #(
  parameter int RESET_HOLD_CYC = igdc_pkg::RESET_HOLD_CYC,
  parameter int BLANKING_CYC   = igdc_pkg::BLANKING_CYC,
  parameter int WATCHDOG_CYC   = igdc_pkg::WATCHDOG_CYC,
  parameter int MIN_PULSE_CYC  = igdc_pkg::MIN_PULSE_CYC
) (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // Drive inputs with their driven flags
  input  wire logic i_drive_noninv,
  input  wire logic i_drive_noninv_driven,
  input  wire logic i_drive_inv,
  input  wire logic i_drive_inv_driven,
  // Low-active reset/enable input
  input  wire logic i_enable_n,
  input  wire logic i_enable_n_driven,
  // Supply comparators
  input  wire logic i_input_supply_below_low,
  input  wire logic i_input_supply_above_high,
  input  wire logic i_output_supply_below_low,
  input  wire logic i_output_supply_above_high,
  // Output-side sense comparators
  input  wire logic i_desaturation_sense_high,
  input  wire logic i_gate_below_clamp,
  // Transmission heartbeat toggle
  input  wire logic i_link_beat,
  // Open-drain status pins
  output logic      o_fault_n_out,
  output logic      o_fault_n_oe,
  output logic      o_ready_out,
  output logic      o_ready_oe,
  // Split gate outputs
  output logic      o_gate_charge_out,
  output logic      o_gate_charge_oe,
  output logic      o_gate_discharge_on,
  // Common gate output and clamp
  output logic      o_gate_out,
  output logic      o_clamp_on
);

  ////////////////////////////////////////////////////////////////////////
  // Resolved pin levels before the filters
  logic noninv_level;   // Non-inverting input after pull-down
  logic inv_level;      // Inverting input after pull-up
  logic enable_level;   // Reset/enable after pull-up

  // Undriven pins fall back to their pull levels
  assign noninv_level = i_drive_noninv_driven ? i_drive_noninv
                                              : igdc_pkg::NONINV_FLOAT_LEVEL;
  assign inv_level    = i_drive_inv_driven ? i_drive_inv
                                           : igdc_pkg::INV_FLOAT_LEVEL;
  assign enable_level = i_enable_n_driven ? i_enable_n
                                          : igdc_pkg::ENABLE_FLOAT_LEVEL;

  ////////////////////////////////////////////////////////////////////////
  // Synchronised and filtered inputs
  logic noninv_f;       // Filtered non-inverting input
  logic inv_f;          // Filtered inverting input
  logic enable_n_f;     // Filtered reset/enable
  logic in_below;       // Input supply under low threshold
  logic in_above;       // Input supply over high threshold
  logic out_below;      // Output supply under low threshold
  logic out_above;      // Output supply over high threshold
  logic desaturation_sense_s;        // Desaturation comparator
  logic clamp_s;        // Gate under clamp threshold
  logic wd_error;       // Transmission timeout

  // Glitch filters on the three logic inputs
  igdc_pin_filter #(.MIN_CYC(MIN_PULSE_CYC), .RST_LEVEL(1'b0)) u_filt_noninv (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (noninv_level),
    .o_level    (noninv_f)
  );
  igdc_pin_filter #(.MIN_CYC(MIN_PULSE_CYC), .RST_LEVEL(1'b1)) u_filt_inv (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (inv_level),
    .o_level    (inv_f)
  );
  igdc_pin_filter #(.MIN_CYC(MIN_PULSE_CYC), .RST_LEVEL(1'b0)) u_filt_enable (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (enable_level),
    .o_level    (enable_n_f)
  );

  // Comparator pins only need synchronising, hence a one-cycle filter
  igdc_pin_filter #(.MIN_CYC(1), .RST_LEVEL(1'b1)) u_sync_in_below (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (i_input_supply_below_low),
    .o_level    (in_below)
  );
  igdc_pin_filter #(.MIN_CYC(1), .RST_LEVEL(1'b0)) u_sync_in_above (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (i_input_supply_above_high),
    .o_level    (in_above)
  );
  igdc_pin_filter #(.MIN_CYC(1), .RST_LEVEL(1'b1)) u_sync_out_below (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (i_output_supply_below_low),
    .o_level    (out_below)
  );
  igdc_pin_filter #(.MIN_CYC(1), .RST_LEVEL(1'b0)) u_sync_out_above (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (i_output_supply_above_high),
    .o_level    (out_above)
  );
  igdc_pin_filter #(.MIN_CYC(1), .RST_LEVEL(1'b0)) u_sync_desaturation_sense (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (i_desaturation_sense_high),
    .o_level    (desaturation_sense_s)
  );
  igdc_pin_filter #(.MIN_CYC(1), .RST_LEVEL(1'b0)) u_sync_clamp (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (i_gate_below_clamp),
    .o_level    (clamp_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // State of the block
  typedef struct packed {
    igdc_pkg::igdc_drive_type    drive;        // Drive state
    logic                        in_lock;      // Input supply lockout
    logic                        out_lock;     // Output supply lockout
    logic                        enable_prev;  // Enable level last cycle
    logic [igdc_pkg::CNT_W-1:0]  low_cnt;      // Length of the enable low phase
    logic [igdc_pkg::CNT_W-1:0]  blank_cnt;    // Blanking progress
    logic                        fault_n_oe;   // Fault pin pulled low
    logic                        ready_oe;     // Ready pin pulled low
    logic                        charge_out;   // Charge output level
    logic                        charge_oe;    // Charge output driving
    logic                        discharge_on; // Discharge output on
    logic                        gate_out;     // Common output level
    logic                        clamp_on;     // Miller clamp on
  } igdc_core_type;

  igdc_core_type st;       // Registered state
  igdc_core_type next_st;  // Next state
  logic          monitor;  // Watchdog may run

  // Watchdog only counts in normal operation, so lockout cannot raise it
  assign monitor = !st.in_lock && !st.out_lock;

  igdc_watchdog #(.TIMEOUT_CYC(WATCHDOG_CYC)) u_watchdog (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_active   (monitor),
    .i_beat     (i_link_beat),
    .o_error    (wd_error)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic command_on;   // Gate requested on
    logic error_mode;   // Lockout or internal error
    logic enable_rise;  // Reset/enable released this cycle
    logic reset_valid;  // Preceding low phase long enough
    logic gate_on;      // Gate on in the next state
    command_on  = 1'b0;
    error_mode  = 1'b0;
    enable_rise = 1'b0;
    reset_valid = 1'b0;
    gate_on     = 1'b0;
    next_st     = st;

    // Lockouts with hysteresis between low and high thresholds
    if (in_below) begin
      next_st.in_lock = 1'b1;
    end else if (in_above) begin
      next_st.in_lock = 1'b0;
    end
    if (out_below) begin
      next_st.out_lock = 1'b1;
    end else if (out_above) begin
      next_st.out_lock = 1'b0;
    end
    error_mode = st.in_lock || st.out_lock || wd_error;

    // Measure the enable low phase, saturating at the hold count
    next_st.enable_prev = enable_n_f;
    if (enable_n_f) begin
      next_st.low_cnt = '0;
    end else if (st.low_cnt < igdc_pkg::CNT_W'(RESET_HOLD_CYC)) begin
      next_st.low_cnt = st.low_cnt + 1'b1;
    end
    enable_rise = enable_n_f && !st.enable_prev;
    reset_valid = st.low_cnt >= igdc_pkg::CNT_W'(RESET_HOLD_CYC);

    // Input combination decides the command; enable low is a shutdown
    command_on = noninv_f && !inv_f && enable_n_f && !error_mode;

    unique case (st.drive)
      igdc_pkg::IGDC_OFF: begin
        next_st.blank_cnt = '0;  // Detector idle while off
        if (command_on) begin
          next_st.drive = igdc_pkg::IGDC_BLANK;
        end
      end
      igdc_pkg::IGDC_BLANK: begin
        if (!command_on) begin
          next_st.drive = igdc_pkg::IGDC_OFF;
        end else if (st.blank_cnt >= igdc_pkg::CNT_W'(BLANKING_CYC - 1)) begin
          next_st.drive = igdc_pkg::IGDC_RUN;
        end else begin
          next_st.blank_cnt = st.blank_cnt + 1'b1;
        end
      end
      igdc_pkg::IGDC_RUN: begin
        // Sense beats a turn-off request so a short is never missed
        if (desaturation_sense_s) begin
          next_st.drive = igdc_pkg::IGDC_FAULT;
        end else if (!command_on) begin
          next_st.drive = igdc_pkg::IGDC_OFF;
        end
      end
      igdc_pkg::IGDC_FAULT: begin
        // Only a release after a long enough low phase leaves the fault
        if (enable_rise && reset_valid) begin
          next_st.drive = igdc_pkg::IGDC_OFF;
        end
      end
    endcase

    // Outputs follow the next drive state so they leave straight from flops
    gate_on = (next_st.drive == igdc_pkg::IGDC_BLANK) ||
              (next_st.drive == igdc_pkg::IGDC_RUN);

    // Fault pin pulled low while the fault is latched
    next_st.fault_n_oe = (next_st.drive == igdc_pkg::IGDC_FAULT);

    // Ready comes only from live status; reset loads it pulled low
    next_st.ready_oe = next_st.in_lock || next_st.out_lock || wd_error;

    // Split outputs: charge floats, discharge pulls, unless gate on
    next_st.charge_out   = gate_on;
    next_st.charge_oe    = gate_on;
    next_st.discharge_on = !gate_on;

    // Common output low in every error and off case
    next_st.gate_out = gate_on;

    // Clamp engages once the gate has sunk below threshold while off
    next_st.clamp_on = !gate_on && clamp_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; reset leaves the gate off and both supplies locked
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st <= '{
        drive:        igdc_pkg::IGDC_OFF,
        in_lock:      igdc_pkg::LOCK_RESET_VALUE,
        out_lock:     igdc_pkg::LOCK_RESET_VALUE,
        enable_prev:  1'b0,
        low_cnt:      '0,
        blank_cnt:    '0,
        fault_n_oe:   1'b0,
        ready_oe:     1'b1,
        charge_out:   1'b0,
        charge_oe:    1'b0,
        discharge_on: 1'b1,
        gate_out:     1'b0,
        clamp_on:     1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ports; open-drain pins only ever drive low
  assign o_fault_n_out       = 1'b0;
  assign o_fault_n_oe        = st.fault_n_oe;
  assign o_ready_out         = 1'b0;
  assign o_ready_oe          = st.ready_oe;
  assign o_gate_charge_out   = st.charge_out;
  assign o_gate_charge_oe    = st.charge_oe;
  assign o_gate_discharge_on = st.discharge_on;
  assign o_gate_out          = st.gate_out;
  assign o_clamp_on          = st.clamp_on;

endmodule : igdc_core

//--- tb/igdc_core_chk.sv
`timescale 1ns/1ps
// Port-level checks of the gate driver control block
module igdc_core_chk #(
  parameter int BLANKING_CYC = igdc_pkg::BLANKING_CYC
) (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // Host pins and their driven flags
  input  wire logic i_drive_noninv,
  input  wire logic i_drive_noninv_driven,
  input  wire logic i_drive_inv,
  input  wire logic i_drive_inv_driven,
  input  wire logic i_enable_n,
  input  wire logic i_enable_n_driven,
  // Comparators
  input  wire logic i_input_supply_below_low,
  input  wire logic i_output_supply_below_low,
  input  wire logic i_desaturation_sense_high,
  input  wire logic i_gate_below_clamp,
  // Outputs under watch
  input  wire logic o_fault_n_oe,
  input  wire logic o_ready_oe,
  input  wire logic o_gate_charge_out,
  input  wire logic o_gate_charge_oe,
  input  wire logic o_gate_discharge_on,
  input  wire logic o_gate_out,
  input  wire logic o_clamp_on
);
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  logic [15:0] on_cnt;  // Cycles the gate has stood on, saturating

  // Counter restarts at every turn-off so blanking is measured per pulse
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !o_gate_out) begin
      on_cnt <= 16'h0000;
    end else if (on_cnt != 16'hFFFF) begin
      on_cnt <= on_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output sets and their modes
  fault_off_a: assert property (o_fault_n_oe |-> !o_gate_out && o_gate_discharge_on)
    else $error("gate on while fault latched");
  drive_on_a: assert property (o_gate_out |-> o_gate_charge_oe && o_gate_charge_out && !o_gate_discharge_on)
    else $error("split outputs disagree with gate on");
  drive_off_a: assert property (!o_gate_out |-> !o_gate_charge_oe && o_gate_discharge_on)
    else $error("split outputs disagree with gate off");
  // Input gating; eight cycles cover sync, filter and output stages with the bench's two-cycle pulse filter
  enable_off_a: assert property ((!i_enable_n && i_enable_n_driven) [*8] |-> !o_gate_out)
    else $error("gate on while enable held low");
  inv_off_a: assert property ((i_drive_inv || !i_drive_inv_driven) [*8] |-> !o_gate_out)
    else $error("gate on with inverting input high");
  noninv_off_a: assert property ((!i_drive_noninv || !i_drive_noninv_driven) [*8] |-> !o_gate_out)
    else $error("gate on with non-inverting input low");
  supply_lock_a: assert property ((i_input_supply_below_low || i_output_supply_below_low) [*6]
    |-> o_ready_oe && !o_gate_out) else $error("lockout not honoured");
  // Clamp
  clamp_gate_a: assert property (o_clamp_on |-> !o_gate_out)
    else $error("clamp on with gate on");
  clamp_on_a: assert property ((i_gate_below_clamp && !o_gate_out) [*5] |-> o_clamp_on)
    else $error("clamp idle below threshold");
  // Desaturation detection and fault latch
  blank_quiet_a: assert property ($rose(o_gate_out) |-> (!o_fault_n_oe) [*8])
    else $error("fault inside blanking");
  desaturation_sense_trip_a: assert property ((i_desaturation_sense_high && on_cnt > 16'(BLANKING_CYC + 4)) [*4]
    |-> ##[0:4] o_fault_n_oe) else $error("desaturation not tripped");
  fault_hold_a: assert property ((o_fault_n_oe && i_enable_n && i_enable_n_driven) [*8] |=> o_fault_n_oe)
    else $error("fault dropped without reset");
  fault_release_a: assert property ($fell(o_fault_n_oe) |-> i_enable_n || !i_enable_n_driven)
    else $error("fault cleared while reset low");
endmodule : igdc_core_chk

bind igdc_core igdc_core_chk #(.BLANKING_CYC(BLANKING_CYC)) u_igdc_core_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_drive_noninv(i_drive_noninv),
  .i_drive_noninv_driven(i_drive_noninv_driven), .i_drive_inv(i_drive_inv), .i_drive_inv_driven(i_drive_inv_driven),
  .i_enable_n(i_enable_n), .i_enable_n_driven(i_enable_n_driven),
  .i_input_supply_below_low(i_input_supply_below_low), .i_output_supply_below_low(i_output_supply_below_low),
  .i_desaturation_sense_high(i_desaturation_sense_high), .i_gate_below_clamp(i_gate_below_clamp),
  .o_fault_n_oe(o_fault_n_oe), .o_ready_oe(o_ready_oe), .o_gate_charge_out(o_gate_charge_out),
  .o_gate_charge_oe(o_gate_charge_oe), .o_gate_discharge_on(o_gate_discharge_on), .o_gate_out(o_gate_out),
  .o_clamp_on(o_clamp_on));

//--- tb/igdc_host_model.sv
`timescale 1ns/1ps
// Host controller model: drive pins and the link heartbeat
module igdc_host_model (
  // Clock
  input  wire logic i_core_clk,
  // Requested levels from the bench
  input  wire logic i_noninv,
  input  wire logic i_inv,
  input  wire logic i_enable_n,
  input  wire logic i_beat_run,
  // Pins toward the block
  output logic      o_drive_noninv,
  output logic      o_drive_inv,
  output logic      o_enable_n,
  output logic      o_link_beat
);
  logic [1:0] div  = 2'h0;  // Beat divider
  logic       beat = 1'b0;  // Heartbeat level, one process drives it

  // Levels follow requests, which change only at the falling edge
  assign o_drive_noninv = i_noninv;
  assign o_drive_inv    = i_inv;
  assign o_enable_n     = i_enable_n;

  assign o_link_beat    = beat;

  // Heartbeat toggles every fourth cycle; stopping it starves the watchdog
  always @(negedge i_core_clk) begin
    div <= div + 2'h1;
    if (i_beat_run && div == 2'h3) begin
      beat <= !beat;
    end
  end
endmodule : igdc_host_model

//--- tb/igdc_core_tb.sv
`timescale 1ns/1ps
// Self-checking bench of the gate driver control block
module igdc_core_tb;
  localparam int HOLD = 10;  // Shortened reset hold
  localparam int WD   = 20;  // Shortened watchdog timeout

  logic clk = 1'b0, rst_n = 1'b0;
  logic noninv = 1'b0, inv = 1'b0, en_n = 1'b1, beat_run = 1'b1;
  logic nd = 1'b1, id = 1'b1, ed = 1'b1;
  logic in_lo = 1'b0, in_hi = 1'b1, out_lo = 1'b0, out_hi = 1'b1;
  logic sense = 1'b0, below = 1'b0;
  wire  p_noninv, p_inv, p_en_n, p_beat;
  wire  f_out, f_oe, r_out, r_oe, c_out, c_oe, d_on, g_out, clamp;
  wire  [5:0] st = {g_out, c_oe, d_on, f_oe, r_oe, clamp};  // Compact status
  int   err_total = 0, n_checks = 0, cycles = 0;

  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  igdc_host_model u_igdc_host_model (.i_core_clk(clk), .i_noninv(noninv), .i_inv(inv), .i_enable_n(en_n),
    .i_beat_run(beat_run), .o_drive_noninv(p_noninv), .o_drive_inv(p_inv), .o_enable_n(p_en_n),
    .o_link_beat(p_beat));

  igdc_core #(.RESET_HOLD_CYC(HOLD), .BLANKING_CYC(10), .WATCHDOG_CYC(WD), .MIN_PULSE_CYC(2)) u_igdc_core (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_drive_noninv(p_noninv), .i_drive_noninv_driven(nd),
    .i_drive_inv(p_inv), .i_drive_inv_driven(id), .i_enable_n(p_en_n), .i_enable_n_driven(ed),
    .i_input_supply_below_low(in_lo), .i_input_supply_above_high(in_hi),
    .i_output_supply_below_low(out_lo), .i_output_supply_above_high(out_hi),
    .i_desaturation_sense_high(sense), .i_gate_below_clamp(below), .i_link_beat(p_beat),
    .o_fault_n_out(f_out), .o_fault_n_oe(f_oe), .o_ready_out(r_out), .o_ready_oe(r_oe),
    .o_gate_charge_out(c_out), .o_gate_charge_oe(c_oe), .o_gate_discharge_on(d_on),
    .o_gate_out(g_out), .o_clamp_on(clamp));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Outputs are levels with no handshake; 20 cycles exceed every path but the watchdog timeout
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////
  // Every input pair, then short pulses and floating pins
  task automatic t_drive;
    for (int k = 0; k < 4; k++) begin
      noninv = k[0];
      inv = k[1];
      cyc(20);
      check(st, (k == 1) ? 6'h30 : 6'h08);
    end
    inv = 1'b0;
    cyc(20);
    check({f_out, r_out, c_out}, 3'h1);
    inv = 1'b1; cyc(1); inv = 1'b0;
    en_n = 1'b0; cyc(1); en_n = 1'b1;
    noninv = 1'b0; cyc(1); noninv = 1'b1;
    cyc(20);
    check(st, 6'h30);
    en_n = 1'b0; cyc(20);
    check(st, 6'h08);
    en_n = 1'b1; nd = 1'b0; cyc(20);
    check(st, 6'h08);
    nd = 1'b1; id = 1'b0; cyc(20);
    check(st, 6'h08);
    id = 1'b1; noninv = 1'b0;
  endtask : t_drive

  // Clamp engages only while the gate is off
  task automatic t_clamp;
    below = 1'b1; cyc(20);
    check(st, 6'h09);
    noninv = 1'b1; cyc(20);
    check(st, 6'h30);
    noninv = 1'b0; below = 1'b0; cyc(20);
  endtask : t_clamp

  // Sense ignored off and in blanking, trip, short and long reset pulses
  task automatic t_desaturation_sense;
    sense = 1'b1; cyc(30);
    check(st, 6'h08);
    noninv = 1'b1; cyc(8);
    check(st, 6'h30);
    cyc(20);
    check(st, 6'h0C);
    noninv = 1'b0; sense = 1'b0; cyc(20);  // Gate discharged before any reset
    en_n = 1'b0; cyc(5); en_n = 1'b1; cyc(20);
    check(st, 6'h0C);
    noninv = 1'b1; cyc(20);
    check(st, 6'h0C);
    noninv = 1'b0; en_n = 1'b0; cyc(HOLD + 10);
    check(st, 6'h0C);
    en_n = 1'b1; cyc(20);
    check(st, 6'h08);
    // Sense rising long after blanking, while the detector is armed
    noninv = 1'b1; cyc(30);
    check(st, 6'h30);
    sense = 1'b1; cyc(10);
    check(st, 6'h0C);
    noninv = 1'b0; sense = 1'b0; cyc(20);  // Gate discharged before the reset
    en_n = 1'b0; cyc(HOLD + 10);
    en_n = 1'b1; cyc(20);
    check(st, 6'h08);
  endtask : t_desaturation_sense

  // Lockout on each supply, the band between thresholds, then recovery
  task automatic t_supply;
    noninv = 1'b1; cyc(20);
    for (int j = 0; j < 2; j++) begin
      {in_lo, in_hi} = (j == 0) ? 2'h2 : 2'h1;
      {out_lo, out_hi} = (j == 1) ? 2'h2 : 2'h1;
      cyc(20);
      check(st, 6'h0A);
      in_lo = 1'b0; out_lo = 1'b0; cyc(20);
      check(st, 6'h0A);
      in_hi = 1'b1; out_hi = 1'b1; cyc(20);
      check(st, 6'h30);
    end
  endtask : t_supply

  // Starved heartbeat, then automatic recovery
  task automatic t_watchdog;
    beat_run = 1'b0; cyc(WD + 20);
    check(st, 6'h0A);
    beat_run = 1'b1; cyc(20);
    check(st, 6'h30);
    noninv = 1'b0;
  endtask : t_watchdog

  ////////////////////////////////////////////////////////////////////////
  // Hang guard well above the expected run of about 730 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    cyc(3);
    rst_n = 1'b1;
    cyc(1);
    check(st, 6'h0A);
    cyc(20);
    check(st, 6'h08);
    t_drive();
    t_clamp();
    t_desaturation_sense();
    t_supply();
    t_watchdog();
    summarize();
  end
endmodule : igdc_core_tb
